//--- hw/eaw_pkg.sv
package eaw_pkg;
  // register indices: the byte address is four times the index
  localparam logic [12:0] IDX_TIMER_CTRL  = 13'h1fc0;
  localparam logic [12:0] IDX_CALC_CTRL   = 13'h1fc1;
  localparam logic [12:0] IDX_PERIOD_SET  = 13'h1fc2;
  localparam logic [12:0] IDX_ANGLE_VALUE = 13'h1fc4;
  localparam logic [12:0] IDX_AMPLITUDE   = 13'h1fc5;
  localparam logic [12:0] IDX_CAPTURE     = 13'h1fc6;
  localparam logic [12:0] IDX_SINE_DATA   = 13'h1fc7;
  localparam logic [12:0] IDX_MOD_PERIOD  = 13'h1fc8;
  localparam logic [12:0] IDX_CMP_U       = 13'h1fc9;
  localparam logic [12:0] IDX_CMP_V       = 13'h1fca;
  localparam logic [12:0] IDX_CMP_W       = 13'h1fcb;
  // timer control fields
  localparam int BIT_DIR        = 7;
  localparam int BIT_PHASE_ORD  = 6;
  localparam int BIT_CLK_HI     = 5;
  localparam int BIT_CLK_LO     = 4;
  localparam int BIT_THREE_PH   = 3;
  localparam int BIT_XFER_EN    = 2;
  localparam int BIT_CALC_EN    = 1;
  localparam int BIT_TIMER_EN   = 0;
  // calculation control fields
  localparam int BIT_SW_START   = 3;
  localparam int BIT_BUSY       = 2;
  localparam int BIT_SYNC_SEL   = 1;
  localparam int BIT_IRQ_SEL    = 0;
  // reset values
  localparam logic [7:0]  RST_TIMER_CTRL = 8'h00;
  localparam logic [3:0]  RST_CALC_CTRL  = 4'h0;
  localparam logic [15:0] RST_PERIOD_SET = 16'h0010;
  localparam logic [15:0] RST_MOD_PERIOD = 16'h0400;
  // counts
  localparam logic [11:0] MIN_PERIOD     = 12'h010;
  localparam logic [8:0]  ANGLE_LAST     = 9'h17f;
  localparam logic [8:0]  ANGLE_HALF     = 9'h0c0;
  localparam logic [8:0]  PHASE_120      = 9'h080;
  localparam logic [8:0]  PHASE_240      = 9'h100;
  localparam int          CALC_CYCLES    = 35;
  localparam int          STEPS_PER_REV  = 384;
  localparam int          STEPS_PER_GRP  = 16;
  localparam logic [5:0]  PRESC_LO_MASK  = 6'h07;
  typedef enum {CS_IDLE, CS_RUN} eaw_calc_t;
endpackage : eaw_pkg

//--- hw/eaw_top.sv
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - per 16 steps, n steps use period m+1, the rest use m.
// - 12-bit step period below 010H acts as 010H.
// - electrical period equals (m+n/16) times 384 timer clocks.
// - angle readable and writable always, counting or stopped; writes above 17FH ignored.
// - result is amplitude times sine entry, amplitude capped by modulation period.
// - position detect strobe latches the angle into the capture register.
// - three-phase sign flips when angle crosses 180 degrees.
// - writing 1 to calc control bit 3 forces a calculation start.
// - calc control bit 2 reads 1 while calculating.
// - calc control bit 1 picks angle-synced start (0) or software only (1).
// - calc control bit 0 picks interrupt at count end (0) or calc end (1).
// - timer control bit 7 sets direction, 0 up, 1 down.
// - timer control bit 6 places V,W at U+120/240 or U-120/240.
// - timer control bits 5:4 select fc/8, fc/16, fc/32, fc/64.
// - timer control bit 3 selects two-phase (0) or three-phase (1).
// - timer control bit 2 enables transfer of results to compare registers.
// - timer control bit 0 enables the angle timer.
// - each calculation completes in 35 cycles after trigger.
// - timer disable stops counting and clears angle to zero.
// - while transfer enabled, software compare register writes are ignored.
// - timer control bit 1 enables the calculation function.
module eaw_top
  import eaw_pkg::*;
(
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic        I_HSEL,
  input  wire logic        I_HREADY,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_POS_DETECT,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  output logic             O_ANGLE_IRQ,
  output logic      [15:0] O_CMP_U,
  output logic      [15:0] O_CMP_V,
  output logic      [15:0] O_CMP_W,
  output logic             O_CMP_LOAD
);

  function automatic logic [8:0] wrap_add(input logic [8:0] a, input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s > {1'b0, ANGLE_LAST}) s = s - 10'(STEPS_PER_REV);
    return s[8:0];
  endfunction : wrap_add

  // bus address phase capture
  logic        wr_pend_ff;
  logic [12:0] wr_idx_ff;
  logic [12:0] rd_idx;
  logic        acc;
  logic        rd_ok;
  assign acc         = I_HSEL & I_HREADY & I_HTRANS[1];
  assign rd_idx      = I_HADDR[14:2];
  assign rd_ok       = acc & ~I_HWRITE;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= '0;
    end else begin
      wr_pend_ff <= acc & I_HWRITE;
      wr_idx_ff  <= rd_idx;
    end
  end

  logic we_tctl, we_cctl, we_per, we_ang, we_amp, we_sin, we_mod, we_cu, we_cv, we_cw;
  assign we_tctl = wr_pend_ff && wr_idx_ff == IDX_TIMER_CTRL;
  assign we_cctl = wr_pend_ff && wr_idx_ff == IDX_CALC_CTRL;
  assign we_per  = wr_pend_ff && wr_idx_ff == IDX_PERIOD_SET;
  assign we_ang  = wr_pend_ff && wr_idx_ff == IDX_ANGLE_VALUE;
  assign we_amp  = wr_pend_ff && wr_idx_ff == IDX_AMPLITUDE;
  assign we_sin  = wr_pend_ff && wr_idx_ff == IDX_SINE_DATA;
  assign we_mod  = wr_pend_ff && wr_idx_ff == IDX_MOD_PERIOD;
  assign we_cu   = wr_pend_ff && wr_idx_ff == IDX_CMP_U;
  assign we_cv   = wr_pend_ff && wr_idx_ff == IDX_CMP_V;
  assign we_cw   = wr_pend_ff && wr_idx_ff == IDX_CMP_W;

  // control registers
  logic [7:0]  tctl_ff;
  logic [1:0]  cctl_ff;
  logic [15:0] per_ff;
  logic [15:0] amp_ff;
  logic [15:0] mod_ff;
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      tctl_ff <= RST_TIMER_CTRL;
      cctl_ff <= RST_CALC_CTRL[1:0];
      per_ff  <= RST_PERIOD_SET;
      amp_ff  <= '0;
      mod_ff  <= RST_MOD_PERIOD;
    end else begin
      if (we_tctl) tctl_ff <= I_HWDATA[7:0];
      if (we_cctl) cctl_ff <= I_HWDATA[1:0];
      if (we_per)  per_ff  <= I_HWDATA[15:0];
      if (we_amp)  amp_ff  <= I_HWDATA[15:0];
      if (we_mod)  mod_ff  <= I_HWDATA[15:0];
    end
  end

  logic timer_en, calc_en, xfer_en;
  assign timer_en = tctl_ff[BIT_TIMER_EN];
  assign calc_en  = tctl_ff[BIT_CALC_EN];
  assign xfer_en  = tctl_ff[BIT_XFER_EN];

  // prescaler: timer clock tick
  logic [5:0] presc_ff;
  logic [5:0] presc_mask;
  logic       tick;
  always_comb begin
    case (tctl_ff[BIT_CLK_HI:BIT_CLK_LO])
      2'd0:    presc_mask = PRESC_LO_MASK;
      2'd1:    presc_mask = {PRESC_LO_MASK[4:0], 1'b1};
      2'd2:    presc_mask = {PRESC_LO_MASK[3:0], 2'b11};
      default: presc_mask = {PRESC_LO_MASK[2:0], 3'b111};
    endcase
  end
  assign tick = timer_en && ((presc_ff & presc_mask) == presc_mask);
  always_ff @(posedge I_MCLK) begin
    if (I_RESET || !timer_en) presc_ff <= '0;
    else                      presc_ff <= presc_ff + 6'h01;
  end

  // step period counter
  logic [11:0] per_m;
  logic [3:0]  corr_n;
  logic [12:0] cnt_ff;
  logic [3:0]  grp_ff;
  logic [12:0] step_len;
  logic        step_end;
  logic [8:0]  angle_ff;
  assign per_m    = (per_ff[11:0] < MIN_PERIOD) ? MIN_PERIOD : per_ff[11:0];
  assign corr_n   = per_ff[15:12];
  assign step_len = {1'b0, per_m} + ((grp_ff < corr_n) ? 13'h0001 : 13'h0000);
  assign step_end = tick && (cnt_ff + 13'h0001 >= step_len);
  always_ff @(posedge I_MCLK) begin
    if (I_RESET || !timer_en) begin
      cnt_ff <= '0;
      grp_ff <= '0;
    end else if (step_end) begin
      cnt_ff <= '0;
      grp_ff <= grp_ff + 4'h1;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 13'h0001;
    end
  end

  // timer enable delayed one clock, so the off edge can clear the angle
  logic ten_d_ff;
  logic ang_clr_seen;
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) ten_d_ff <= 1'b0;
    else         ten_d_ff <= timer_en;
  end
  assign ang_clr_seen = ten_d_ff && !timer_en;

  // angle counter; cleared once on disable so table loading can still set it
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      angle_ff <= '0;
    end else if (we_ang) begin
      if (I_HWDATA[15:0] <= {7'h00, ANGLE_LAST}) angle_ff <= I_HWDATA[8:0];
    end else if (ang_clr_seen) begin
      angle_ff <= 9'h000;
    end else if (step_end) begin
      if (tctl_ff[BIT_DIR]) angle_ff <= (angle_ff == 9'h000) ? ANGLE_LAST : angle_ff - 9'h001;
      else                  angle_ff <= (angle_ff == ANGLE_LAST) ? 9'h000 : angle_ff + 9'h001;
    end
  end
  // capture on position detect
  logic [8:0] cap_ff;
  always_ff @(posedge I_MCLK) begin
    if (I_RESET)           cap_ff <= '0;
    else if (I_POS_DETECT) cap_ff <= angle_ff;
  end

  // sine ram, written at the angle address
  logic [15:0] sine_mem [STEPS_PER_REV];
  always_ff @(posedge I_MCLK) begin
    if (we_sin) sine_mem[angle_ff] <= I_HWDATA[15:0];
  end

  // calculation sequencer
  eaw_calc_t   cstate_ff;
  logic [5:0]  ccnt_ff;
  logic        sw_start, sync_start, start, calc_done;
  logic [8:0]  ang_lat_ff;
  logic [15:0] res_ff [3];
  assign sw_start   = we_cctl && I_HWDATA[BIT_SW_START];
  assign sync_start = !cctl_ff[BIT_SYNC_SEL] && (step_end || we_ang);
  assign start      = calc_en && (sw_start || sync_start);
  assign calc_done  = cstate_ff == CS_RUN && ccnt_ff == 6'(CALC_CYCLES - 1);
  always_ff @(posedge I_MCLK) begin
    if (I_RESET || !calc_en) begin
      cstate_ff <= CS_IDLE;
      ccnt_ff   <= '0;
    end else begin
      case (cstate_ff)
        CS_IDLE: begin
          if (start) begin
            cstate_ff <= CS_RUN;
            ccnt_ff   <= '0;
          end
        end
        CS_RUN: begin
          if (start)          ccnt_ff   <= '0;
          else if (calc_done) cstate_ff <= CS_IDLE;
          else                ccnt_ff   <= ccnt_ff + 6'h01;
        end
        default: cstate_ff <= CS_IDLE;
      endcase
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RESET)    ang_lat_ff <= '0;
    else if (start) ang_lat_ff <= angle_ff;
  end

  // arithmetic: all three phases in parallel, results held until the last cycle
  logic [8:0]  ph_ang [3];
  logic [15:0] amp_eff;
  assign amp_eff = (amp_ff > mod_ff) ? mod_ff : amp_ff;
  assign ph_ang[0] = ang_lat_ff;
  assign ph_ang[1] = tctl_ff[BIT_PHASE_ORD] ? wrap_add(ang_lat_ff, PHASE_240)
                                            : wrap_add(ang_lat_ff, PHASE_120);
  assign ph_ang[2] = tctl_ff[BIT_PHASE_ORD] ? wrap_add(ang_lat_ff, PHASE_120)
                                            : wrap_add(ang_lat_ff, PHASE_240);
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      logic [31:0] prod;
      logic [15:0] half;
      logic [15:0] val;
      assign prod = sine_mem[ph_ang[g]] * amp_eff;
      assign half = {1'b0, prod[31:17]};
      always_comb begin
        if (!tctl_ff[BIT_THREE_PH])    val = prod[31:16];
        else if (ph_ang[g] < ANGLE_HALF) val = (mod_ff >> 1) + half;
        else                           val = (mod_ff >> 1) - half;
      end
      always_ff @(posedge I_MCLK) begin
        if (I_RESET)        res_ff[g] <= '0;
        else if (calc_done) res_ff[g] <= val;
      end
    end
  endgenerate

  // compare registers toward the pwm generator
  logic xfer_ff;
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_CMP_U <= '0;
      O_CMP_V <= '0;
      O_CMP_W <= '0;
      xfer_ff <= 1'b0;
    end else begin
      xfer_ff <= calc_done && xfer_en;
      if (xfer_ff) begin
        O_CMP_U <= res_ff[0];
        O_CMP_V <= res_ff[1];
        O_CMP_W <= res_ff[2];
      end else if (!xfer_en) begin
        if (we_cu) O_CMP_U <= I_HWDATA[15:0];
        if (we_cv) O_CMP_V <= I_HWDATA[15:0];
        if (we_cw) O_CMP_W <= I_HWDATA[15:0];
      end
    end
  end
  assign O_CMP_LOAD = xfer_ff;

  // interrupt pulse
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) O_ANGLE_IRQ <= 1'b0;
    else O_ANGLE_IRQ <= cctl_ff[BIT_IRQ_SEL] ? calc_done : step_end;
  end

  // read data
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_HRDATA <= '0;
    end else if (rd_ok) begin
      case (rd_idx)
        IDX_TIMER_CTRL:  O_HRDATA <= {24'h00_0000, tctl_ff};
        IDX_CALC_CTRL:   O_HRDATA <= {28'h000_0000, 1'b0, cstate_ff == CS_RUN, cctl_ff};
        IDX_PERIOD_SET:  O_HRDATA <= {16'h0000, per_ff};
        IDX_ANGLE_VALUE: O_HRDATA <= {23'h00_0000, angle_ff};
        IDX_AMPLITUDE:   O_HRDATA <= {16'h0000, amp_ff};
        IDX_CAPTURE:     O_HRDATA <= {23'h00_0000, cap_ff};
        IDX_MOD_PERIOD:  O_HRDATA <= {16'h0000, mod_ff};
        IDX_CMP_U:       O_HRDATA <= {16'h0000, O_CMP_U};
        IDX_CMP_V:       O_HRDATA <= {16'h0000, O_CMP_V};
        IDX_CMP_W:       O_HRDATA <= {16'h0000, O_CMP_W};
        default:         O_HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // cycles since the last start, so restarts are timed as well
  logic [5:0] calc_age_ff;
  always_ff @(posedge I_MCLK) begin
    if (I_RESET || start)          calc_age_ff <= 6'h01;
    else if (calc_age_ff != 6'h3f) calc_age_ff <= calc_age_ff + 6'h01;
  end

  sequence s_calc_kick;
    cstate_ff == CS_IDLE && start;
  endsequence
  sequence s_sw_kick;
    calc_en && we_cctl && I_HWDATA[BIT_SW_START];
  endsequence
  sequence s_run_fresh;
    cstate_ff == CS_RUN && ccnt_ff == 6'h00;
  endsequence
  sequence s_xfer_due;
    calc_done && xfer_en;
  endsequence
  sequence s_cmp_update;
    O_CMP_LOAD ##1 (O_CMP_U == $past(res_ff[0]) && O_CMP_V == $past(res_ff[1])
                    && O_CMP_W == $past(res_ff[2]));
  endsequence

  a_calc_time: assert property (@(posedge I_MCLK)
    disable iff (I_RESET || !calc_en || (cstate_ff == CS_RUN && start))
    s_calc_kick |-> ##35 calc_done) else $error("calc length wrong");
  a_calc_age: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    calc_done |-> calc_age_ff == 6'(CALC_CYCLES)) else $error("calc end not timed from start");
  a_busy_flag: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (calc_done && !start) |=> cstate_ff == CS_IDLE) else $error("busy not cleared");
  a_busy_read: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (rd_ok && rd_idx == IDX_CALC_CTRL && cstate_ff == CS_RUN)
      |=> O_HRDATA[BIT_BUSY]) else $error("busy bit not read");
  a_sw_start: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    s_sw_kick |=> s_run_fresh) else $error("software start ignored");
  a_zero_noop: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (cstate_ff == CS_IDLE && we_cctl && !I_HWDATA[BIT_SW_START] && !sync_start)
      |=> cstate_ff == CS_IDLE) else $error("start on zero write");
  a_angle_range: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    angle_ff <= ANGLE_LAST) else $error("angle out of range");
  a_angle_clear: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (ang_clr_seen && !we_ang) |=> angle_ff == 9'h000) else $error("angle not cleared");
  a_angle_reject: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (we_ang && I_HWDATA[15:0] > {7'h00, ANGLE_LAST})
      |=> $stable(angle_ff)) else $error("angle write not rejected");
  a_cap_latch: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    I_POS_DETECT |=> cap_ff == $past(angle_ff)) else $error("capture missed");
  a_xfer_block: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (xfer_en && we_cu && !xfer_ff) |=> $stable(O_CMP_U)) else $error("cmp written");
  a_xfer_load: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    s_xfer_due |=> s_cmp_update) else $error("results not transferred");
  a_irq_src: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (step_end && !cctl_ff[BIT_IRQ_SEL]) |=> O_ANGLE_IRQ) else $error("irq missing");
  a_min_period: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    step_len >= 13'(MIN_PERIOD)) else $error("period below minimum");
  a_no_calc_off: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    !calc_en |=> cstate_ff == CS_IDLE) else $error("calc while disabled");
  a_step_adv: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (step_end && !we_ang && !tctl_ff[BIT_DIR] && angle_ff != ANGLE_LAST)
      |=> angle_ff == $past(angle_ff) + 9'h001) else $error("angle not advanced");

endmodule : eaw_top
`default_nettype wire

//--- verif/eaw_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module eaw_top_tb
  import eaw_pkg::*;
;
  logic        clk, rst, hwrite, hsel, hready, hresp, pos_det, irq, cmp_load;
  logic [31:0] haddr, hwdata, hrdata, rdv, lfsr;
  logic [1:0]  htrans;
  logic [15:0] cmp_u, cmp_v, cmp_w, eu, ev, ew, voltage_amplitude;
  logic [15:0] sv [3];
  logic [8:0]  ang, pa [3];
  int          bad_count, n_compared, cyc, n, tot, nlong, m, nc;
  logic        seen, three, ord;

  eaw_top i_eaw_top (.I_MCLK(clk), .I_RESET(rst), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HSEL(hsel), .I_HREADY(hready), .I_HWDATA(hwdata),
    .I_POS_DETECT(pos_det), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .O_ANGLE_IRQ(irq), .O_CMP_U(cmp_u), .O_CMP_V(cmp_v), .O_CMP_W(cmp_w),
    .O_CMP_LOAD(cmp_load));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [15:0] calc_exp(input logic [15:0] s, input logic [15:0] a,
                                           input logic th, input logic [8:0] g);
    logic [31:0] p;
    p = s * ((a > RST_MOD_PERIOD) ? RST_MOD_PERIOD : a);
    if (!th) return p[31:16];
    return (g < ANGLE_HALF) ? (RST_MOD_PERIOD >> 1) + p[31:17] : (RST_MOD_PERIOD >> 1) - p[31:17];
  endfunction : calc_exp

  function automatic logic [8:0] phase(input logic [8:0] g, input int off, input logic o);
    return 9'((o ? (g + STEPS_PER_REV - off) : (g + off)) % STEPS_PER_REV);
  endfunction : phase

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_t(input int got, input int lo, input int hi, input string what);
    n_compared++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("MISMATCH t=%0t %s cycles %0d exp %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_t

  task automatic bus(input logic [12:0] idx, input logic w, input logic [31:0] d);
    @(posedge clk);
    haddr  <= {17'h0_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    hsel   <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask : bus

  task automatic wr(input logic [12:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [12:0] idx);
    bus(idx, 1'b0, 32'h0000_0000);
  endtask : rd

  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (irq !== 1'b1 && k < 9000);
  endtask : wait_irq

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    {rst, hwrite, hsel, pos_det} = 4'b1000;
    {haddr, hwdata, htrans} = '0;
    lfsr = 32'h0000_f2ae;
    {bad_count, n_compared, cyc} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_TIMER_CTRL);  chk(rdv[7:0], RST_TIMER_CTRL, "timer ctrl reset");
    rd(IDX_CALC_CTRL);   chk(rdv[3:0], RST_CALC_CTRL, "calc ctrl reset");
    rd(IDX_PERIOD_SET);  chk(rdv[15:0], RST_PERIOD_SET, "period reset");
    rd(13'h0100);        chk(rdv, 32'h0000_0000, "unmapped read");
    chk(hresp, 1'b0, "okay response");
    wr(IDX_ANGLE_VALUE, 32'h0000_017f);
    wr(IDX_ANGLE_VALUE, 32'h0000_0180);
    rd(IDX_ANGLE_VALUE); chk(rdv[8:0], ANGLE_LAST, "angle reject");
    $display("test registers done");
    wr(IDX_TIMER_CTRL, 32'h0000_0001);
    wait_irq(n); rd(IDX_ANGLE_VALUE); ang = rdv[8:0];
    wait_irq(n); rd(IDX_ANGLE_VALUE); chk(rdv[8:0], phase(ang, 1, 1'b0), "step up");
    wr(IDX_ANGLE_VALUE, 32'h0000_017f);
    wait_irq(n); rd(IDX_ANGLE_VALUE); chk(rdv[8:0], 9'h000, "wrap up");
    wr(IDX_TIMER_CTRL, 32'h0000_0081);
    wr(IDX_ANGLE_VALUE, 32'h0000_0000);
    wait_irq(n); rd(IDX_ANGLE_VALUE); chk(rdv[8:0], ANGLE_LAST, "wrap down");
    wr(IDX_TIMER_CTRL, 32'h0000_0000);
    rd(IDX_ANGLE_VALUE); chk(rdv[8:0], 9'h000, "disable clears");
    $display("test angle done");
    for (int s = 0; s < 4; s++) begin
      lfsr = lfsr_next(lfsr);
      wr(IDX_PERIOD_SET, {28'h0, lfsr[3:0]});
      wr(IDX_TIMER_CTRL, 32'(s << 4));
      wr(IDX_TIMER_CTRL, 32'(s << 4) | 32'h1);
      wait_irq(n); wait_irq(n);
      chk_t(n, 16 * (8 << s), 16 * (8 << s), "clock select");
      wr(IDX_TIMER_CTRL, 32'h0000_0000);
    end
    lfsr = lfsr_next(lfsr);
    m  = 16 + int'(lfsr[5:0]);
    nc = int'(lfsr[11:8]);
    wr(IDX_PERIOD_SET, 32'(nc << 12 | m));
    wr(IDX_TIMER_CTRL, 32'h0000_0001);
    wait_irq(n);
    tot = 0; nlong = 0;
    for (int i = 0; i < STEPS_PER_GRP; i++) begin
      wait_irq(n);
      tot += n;
      if (n == (m + 1) * 8) nlong++;
    end
    chk_t(tot, (16 * m + nc) * 8, (16 * m + nc) * 8, "electrical period");
    chk_t(nlong, nc, nc, "corrected steps");
    $display("test period done");
    wr(IDX_TIMER_CTRL, 32'h0000_0000);
    wr(IDX_PERIOD_SET, 32'h0000_ffff);
    wr(IDX_TIMER_CTRL, 32'h0000_0031);
    wr(IDX_ANGLE_VALUE, {23'h0, 9'(lfsr % STEPS_PER_REV)});
    @(posedge clk) pos_det <= 1'b1;
    @(posedge clk) pos_det <= 1'b0;
    rd(IDX_CAPTURE); chk(rdv[8:0], 9'(lfsr % STEPS_PER_REV), "capture");
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      ang = (k == 1) ? 9'h0bf : (k == 2) ? ANGLE_HALF : 9'(lfsr % STEPS_PER_REV);
      three = (k == 1 || k == 2);
      ord = k[0];
      voltage_amplitude = (k == 3) ? 16'hffff : {6'h0, lfsr[25:16]};
      wr(IDX_TIMER_CTRL, 32'h31 | 32'(ord) << 6 | 32'(three) << 3);
      wr(IDX_CALC_CTRL, 32'h0000_0003);
      for (int p = 0; p < 3; p++) begin
        lfsr = lfsr_next(lfsr);
        pa[p] = phase(ang, p * 128, ord);
        sv[p] = lfsr[15:0];
        wr(IDX_ANGLE_VALUE, {23'h0, pa[p]});
        wr(IDX_SINE_DATA, {16'h0, sv[p]});
      end
      wr(IDX_ANGLE_VALUE, {23'h0, ang});
      wr(IDX_AMPLITUDE, {16'h0, voltage_amplitude});
      wr(IDX_TIMER_CTRL, 32'h37 | 32'(ord) << 6 | 32'(three) << 3);
      wr(IDX_CALC_CTRL, 32'h0000_0003);
      rd(IDX_CALC_CTRL); chk(rdv[BIT_BUSY], 1'b0, "no start on 0");
      wr(IDX_CALC_CTRL, 32'h0000_000b);
      n = 0; seen = 1'b0;
      do begin
        @(posedge clk);
        n++;
        if (irq === 1'b1) seen = 1'b1;
      end while (cmp_load !== 1'b1 && n < 200);
      chk_t(n, CALC_CYCLES, CALC_CYCLES + 2, "calc time");
      chk(seen, 1'b1, "calc end irq");
      @(posedge clk);
      eu = calc_exp(sv[0], voltage_amplitude, three, pa[0]);
      ev = calc_exp(sv[1], voltage_amplitude, three, pa[1]);
      ew = calc_exp(sv[2], voltage_amplitude, three, pa[2]);
      chk({cmp_u, cmp_v, cmp_w}, {eu, ev, ew}, "phase results");
      wr(IDX_CALC_CTRL, 32'h0000_000b);
      rd(IDX_CALC_CTRL); chk(rdv[BIT_BUSY], 1'b1, "busy");
    end
    $display("test calculation done");
    repeat (40) @(posedge clk);
    wr(IDX_CMP_U, 32'h0000_1234);
    rd(IDX_CMP_U); chk(rdv[15:0], eu, "cmp write ignored");
    wr(IDX_TIMER_CTRL, 32'h0000_0031);
    wr(IDX_CMP_U, 32'h0000_5a5a);
    rd(IDX_CMP_U); chk(rdv[15:0], 16'h5a5a, "cmp write");
    wr(IDX_CALC_CTRL, 32'h0000_000a);
    rd(IDX_CALC_CTRL); chk(rdv[BIT_BUSY], 1'b0, "calc disabled");
    wr(IDX_TIMER_CTRL, 32'h0000_0033);
    wr(IDX_CALC_CTRL, 32'h0000_0000);
    wr(IDX_ANGLE_VALUE, 32'h0000_0010);
    rd(IDX_CALC_CTRL); chk(rdv[BIT_BUSY], 1'b1, "sync start");
    repeat (40) @(posedge clk);
    wr(IDX_CALC_CTRL, 32'h0000_0002);
    wr(IDX_ANGLE_VALUE, 32'h0000_0020);
    rd(IDX_CALC_CTRL); chk(rdv[BIT_BUSY], 1'b0, "software only");
    $display("test control done");
    end_sim();
  end
endmodule : eaw_top_tb
`default_nettype wire
